// ===== design/lpx_dev.sv
// Device end: command decode, mode registers, bank state, self refresh.
// Assumes the controller drives the pins synchronously to ref_clk.
`timescale 1ns/1ps
module lpx_dev
  import lpx_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  lpx_link_if.dev                link,
  input  wire logic [7:0]        temp_code,
  output logic [EXT_W-1:0]       ext_cfg,
  output logic [ADDR_W-1:0]      base_cfg,
  output logic [NBANK-1:0]       bank_open,
  output logic [NBANK-1:0]       bank_retained,
  output logic [2:0]             drive_code,
  output logic                   cov_reserved,
  output logic                   drive_reserved,
  output logic                   self_refresh,
  output logic                   deep_sleep_state,
  output logic                   sref_tick,
  output logic                   cmd_valid,
  output logic [3:0]             cmd_code,
  output logic [BANK_W-1:0]      cmd_bank,
  output logic [ADDR_W-1:0]      cmd_row,
  output logic [COL_W-1:0]       cmd_col,
  output logic                   cmd_auto_pre,
  output logic [MASK_W-1:0]      wr_mask,
  output logic [MASK_W-1:0]      rd_mask
);
  lpx_cmd_t cmd;
  logic [EXT_W-1:0]  ext_r, ext_nxt;
  logic [ADDR_W-1:0] base_r, base_nxt;
  logic [NBANK-1:0]  open_r, open_nxt, keep_r, keep_nxt;
  logic [ADDR_W-1:0] row_r [NBANK];
  logic              sref_r, sref_nxt, dsl_r, dsl_nxt;
  logic [15:0]       scnt_r, scnt_nxt, sper;
  logic              tick_r, tick_nxt;
  logic [MASK_W-1:0] rdm_pipe_r [READ_MASK_LAT];
  logic [MASK_W-1:0] wrm_r;
  logic              covres_r, covres_nxt, drvres_r, drvres_nxt;

  assign cmd = lpx_decode(link.cke, link.cs_n, link.ras_n, link.cas_n,
                          link.we_n);

  // Banks that keep data in self refresh for a coverage code.
  function automatic logic [NBANK-1:0] cov_banks(input logic [2:0] c);
    logic [NBANK-1:0] b;
    b = 4'hf;
    unique case (c)
      COV_HALF: b = 4'h3;
      COV_QTR, COV_8TH, COV_16TH: b = 4'h1;
      default: b = 4'hf;
    endcase
    return b;
  endfunction

  // Mode registers, bank state and power states.
  always_comb
  begin
    ext_nxt  = ext_r;
    base_nxt = base_r;
    open_nxt = open_r;
    keep_nxt = keep_r;
    sref_nxt = sref_r;
    dsl_nxt  = dsl_r;
    if (sref_r)
    begin
      if (link.cke)
        sref_nxt = 1'b0;
    end
    else if (dsl_r)
    begin
      if (link.cke)
        dsl_nxt = 1'b0;
    end
    else
      unique case (cmd)
        CMD_ACTIVATE:
          open_nxt[link.bank] = 1'b1;
        CMD_PRECHARGE:
          if (link.addr[AP_BIT])
            open_nxt = '0;
          else
            open_nxt[link.bank] = 1'b0;
        CMD_READ, CMD_WRITE:
        begin
          keep_nxt[link.bank] = 1'b1;
          if (link.addr[AP_BIT])
            open_nxt[link.bank] = 1'b0;
        end
        CMD_MODE_SET:
          if (link.bank == BANK_SEL_EXT)
            ext_nxt = {link.bank, link.addr};
          else if (link.bank == BANK_SEL_BASE)
            base_nxt = link.addr;
        CMD_SELF_REFRESH:
        begin
          sref_nxt = 1'b1;
          keep_nxt = keep_r & cov_banks(ext_r[COV_HI:COV_LO]);
        end
        CMD_DEEP_SLEEP:
        begin
          dsl_nxt  = 1'b1;
          open_nxt = '0;
          keep_nxt = '0;
        end
        default: ;
      endcase
    // Reserved-code flags track the value the register will hold next.
    covres_nxt = ext_nxt[COV_HI:COV_LO] inside {3'h3, 3'h4, 3'h7};
    drvres_nxt = ext_nxt[DRV_HI:DRV_LO] > DRV_3QTR;
  end

  // Self refresh period follows the on-chip temperature reading.
  always_comb
  begin
    if (temp_code >= TEMP_HOT)
      sper = SREF_PER_HOT;
    else if (temp_code >= TEMP_WARM)
      sper = SREF_PER_WARM;
    else
      sper = SREF_PER_COLD;
    scnt_nxt = '0;
    tick_nxt = 1'b0;
    if (sref_r)
    begin
      if (scnt_r + 16'h0001 >= sper)
        tick_nxt = 1'b1;
      else
        scnt_nxt = scnt_r + 16'h0001;
    end
  end

  // Registers; the extended register changes only on its own load.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ext_r  <= EXT_RESET;
      base_r <= BASE_RESET;
      open_r <= '0;
      keep_r <= '0;
      sref_r <= 1'b0;
      dsl_r  <= 1'b0;
      scnt_r <= '0;
      tick_r <= 1'b0;
      covres_r <= 1'b0;
      drvres_r <= 1'b0;
    end
    else
    begin
      ext_r  <= ext_nxt;
      base_r <= base_nxt;
      open_r <= open_nxt;
      keep_r <= keep_nxt;
      sref_r <= sref_nxt;
      dsl_r  <= dsl_nxt;
      scnt_r <= scnt_nxt;
      tick_r <= tick_nxt;
      covres_r <= covres_nxt;
      drvres_r <= drvres_nxt;
    end
  end

  // Open row per bank, registered command fields and byte masks.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NBANK; i++)
        row_r[i] <= '0;
      for (int i = 0; i < READ_MASK_LAT; i++)
        rdm_pipe_r[i] <= '0;
      wrm_r        <= '0;
      cmd_valid    <= 1'b0;
      cmd_code     <= '0;
      cmd_bank     <= '0;
      cmd_row      <= '0;
      cmd_col      <= '0;
      cmd_auto_pre <= 1'b0;
    end
    else
    begin
      if (cmd == CMD_ACTIVATE && !sref_r && !dsl_r)
        row_r[link.bank] <= link.addr;
      wrm_r         <= (cmd == CMD_WRITE) ? link.dqm : '0;
      rdm_pipe_r[0] <= link.dqm;
      for (int i = 1; i < READ_MASK_LAT; i++)
        rdm_pipe_r[i] <= rdm_pipe_r[i-1];
      cmd_valid <= !sref_r && !dsl_r && cmd != CMD_INHIBIT
                   && cmd != CMD_NOP && cmd != CMD_ILLEGAL;
      cmd_code  <= cmd;
      cmd_bank  <= link.bank;
      if (cmd == CMD_AUTO_REFRESH)
        cmd_row <= '0;
      else if (cmd == CMD_READ || cmd == CMD_WRITE)
        cmd_row <= row_r[link.bank];
      else
        cmd_row <= link.addr;
      cmd_col   <= link.addr[COL_W-1:0];
      cmd_auto_pre <= link.addr[AP_BIT]
                      && (cmd == CMD_READ || cmd == CMD_WRITE);
    end
  end

  // Outputs straight from flip-flops.
  always_comb
  begin
    ext_cfg          = ext_r;
    base_cfg         = base_r;
    bank_open        = open_r;
    bank_retained    = keep_r;
    drive_code       = ext_r[DRV_HI:DRV_LO];
    cov_reserved     = covres_r;
    drive_reserved   = drvres_r;
    self_refresh     = sref_r;
    deep_sleep_state = dsl_r;
    sref_tick        = tick_r;
    wr_mask          = wrm_r;
    rd_mask          = rdm_pipe_r[READ_MASK_LAT-1];
  end
endmodule

// ===== design/lpx_pkg.sv
// Shared constants for the low-power SDRAM command decode link.
// Assumes both ends run on one ref_clk and meet through lpx_link_if.
// Behaviour
// - Mode load with bank 10 selects extended register.
// - Extended register holds until rewritten.
// - Controller drives bits 11..8, 4, 3 low.
// - Extended load only when idle, no burst.
// - Mode loads when idle, then wait recovery.
// - Bits 2..0 choose self refresh coverage.
// - Access any bank; self refresh keeps selected.
// - Bits 7..5 choose output drive strength.
// - Self refresh rate follows on-chip temperature.
// - Chip select high accepts no command.
// - No-op registers nothing, operations continue.
// - Activate opens row in addressed bank.
// - Precharge bank before activating another row.
// - Read/write take column, bank, auto precharge.
// - Precharge one bank, or all with bit10.
// - Refresh auto with enable high, self otherwise.
// - Byte masks: writes same cycle, reads two later.
// - All strobes low loads a mode register.
// - Enable low with write low enters deep sleep.
// - Enable high except self refresh, deep sleep.
// - Reinitialise fully after leaving deep sleep.
package lpx_pkg;
  localparam int ADDR_W     = 12;
  localparam int BANK_W     = 2;
  localparam int NBANK      = 4;
  localparam int MASK_W     = 4;
  localparam int EXT_W      = 14;
  localparam int COL_W      = 8;
  localparam int AP_BIT     = 10;
  localparam int READ_MASK_LAT = 2;
  localparam logic [1:0] BANK_SEL_BASE = 2'h0;
  localparam logic [1:0] BANK_SEL_EXT  = 2'h2;
  localparam int COV_LO = 0;
  localparam int COV_HI = 2;
  localparam int DRV_LO = 5;
  localparam int DRV_HI = 7;
  localparam logic [13:0] EXT_RESET = 14'h2000;
  localparam logic [11:0] BASE_RESET = 12'h000;
  // Coverage codes.
  localparam logic [2:0] COV_ALL  = 3'h0;
  localparam logic [2:0] COV_HALF = 3'h1;
  localparam logic [2:0] COV_QTR  = 3'h2;
  localparam logic [2:0] COV_8TH  = 3'h5;
  localparam logic [2:0] COV_16TH = 3'h6;
  // Drive strength codes.
  localparam logic [2:0] DRV_FULL = 3'h0;
  localparam logic [2:0] DRV_HALF = 3'h1;
  localparam logic [2:0] DRV_QTR  = 3'h2;
  localparam logic [2:0] DRV_8TH  = 3'h3;
  localparam logic [2:0] DRV_3QTR = 3'h4;
  // Mode-set recovery time in ns and as whole cycles at 40 MHz.
  localparam int MODE_SET_RECOVERY_NS = 2;
  localparam int CLK_PERIOD_PS = 25000;
  localparam int MRD_CYC_RAW =
    (MODE_SET_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int MODE_SET_RECOVERY_CYC = (MRD_CYC_RAW < 1) ? 1 : MRD_CYC_RAW;
  // Temperature thresholds in sensor codes, refresh periods in cycles.
  localparam logic [7:0] TEMP_HOT  = 8'h46;
  localparam logic [7:0] TEMP_WARM = 8'h2d;
  localparam logic [15:0] SREF_PER_COLD = 16'h0800;
  localparam logic [15:0] SREF_PER_WARM = 16'h0400;
  localparam logic [15:0] SREF_PER_HOT  = 16'h0200;

  typedef enum logic [3:0] {
    CMD_INHIBIT, CMD_NOP, CMD_ACTIVATE, CMD_READ, CMD_WRITE, CMD_BURST_STOP,
    CMD_PRECHARGE, CMD_AUTO_REFRESH, CMD_SELF_REFRESH, CMD_MODE_SET,
    CMD_DEEP_SLEEP, CMD_ILLEGAL
  } lpx_cmd_t;

  // Decodes the pin levels into a command; chip select high wins.
  function automatic lpx_cmd_t lpx_decode(input logic cke, input logic cs_n,
      input logic ras_n, input logic cas_n, input logic we_n);
    lpx_cmd_t c;
    c = CMD_ILLEGAL;
    if (cs_n)
      c = CMD_INHIBIT;
    else if (cke)
      unique case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NOP;
        3'h3: c = CMD_ACTIVATE;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h6: c = CMD_BURST_STOP;
        3'h2: c = CMD_PRECHARGE;
        3'h1: c = CMD_AUTO_REFRESH;
        3'h0: c = CMD_MODE_SET;
      endcase
    else if ({ras_n, cas_n, we_n} == 3'h1)
      c = CMD_SELF_REFRESH;
    else if ({ras_n, cas_n, we_n} == 3'h6)
      c = CMD_DEEP_SLEEP;
    return c;
  endfunction
endpackage

// ===== design/lpx_link_if.sv
// Command pins between memory controller and low-power SDRAM decoder.
// Assumes both ends sample on the same ref_clk rising edge.
`timescale 1ns/1ps
interface lpx_link_if
  import lpx_pkg::*;
();
  logic              cke;
  logic              cs_n;
  logic              ras_n;
  logic              cas_n;
  logic              we_n;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] addr;
  logic [MASK_W-1:0] dqm;

  modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank, addr, dqm);
  modport dev  (input cke, cs_n, ras_n, cas_n, we_n, bank, addr, dqm);
endinterface

// ===== design/lpx_ctrl.sv
// Controller end: turns user requests into legal command pin patterns.
// Assumes the user issues one request at a time and waits for ready.
`timescale 1ns/1ps
module lpx_ctrl
  import lpx_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  lpx_link_if.ctrl               link,
  input  wire logic              req_valid,
  input  wire logic [3:0]        req_cmd,
  input  wire logic [BANK_W-1:0] req_bank,
  input  wire logic [ADDR_W-1:0] req_addr,
  input  wire logic [MASK_W-1:0] req_dqm,
  input  wire logic              bursts_idle,
  output logic                   req_ready,
  output logic                   req_reject
);
  typedef enum logic [1:0] {ST_IDLE, ST_RECOVER, ST_SLEEP} lpx_cst_t;
  lpx_cst_t st_r, st_nxt;
  logic [7:0] wait_r, wait_nxt;
  logic [NBANK-1:0] open_r, open_nxt;
  logic cke_nxt, cs_nxt, ras_nxt, cas_nxt, we_nxt, rej_nxt;
  logic [BANK_W-1:0] bank_nxt;
  logic [ADDR_W-1:0] addr_nxt;
  logic ok;

  // Pick pins for the request, refusing illegal sequences.
  always_comb
  begin
    st_nxt = st_r;
    wait_nxt = wait_r;
    open_nxt = open_r;
    {cke_nxt, cs_nxt, ras_nxt, cas_nxt, we_nxt} = 5'h1f;
    bank_nxt = link.bank;
    addr_nxt = link.addr;
    rej_nxt = 1'b0;
    ok = 1'b1;
    unique case (st_r)
      ST_RECOVER:
      begin
        cs_nxt = 1'b0;
        if (wait_r <= 8'h01)
          st_nxt = ST_IDLE;
        else
          wait_nxt = wait_r - 8'h01;
      end
      ST_SLEEP:
      begin
        cke_nxt = 1'b0;
        if (req_valid && req_cmd == CMD_NOP)
        begin
          cke_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
      ST_IDLE:
        if (req_valid)
        begin
          unique case (req_cmd)
            CMD_ACTIVATE: ok = !open_r[req_bank];
            CMD_READ, CMD_WRITE: ok = open_r[req_bank];
            CMD_AUTO_REFRESH, CMD_SELF_REFRESH, CMD_DEEP_SLEEP:
              ok = (open_r == '0);
            CMD_MODE_SET:
              ok = (open_r == '0) && bursts_idle
                && (req_bank != BANK_SEL_EXT
                || (req_addr[11:8] == 4'h0 && req_addr[4:3] == 2'h0
                && !(req_addr[2:0] inside {3'h3, 3'h4, 3'h7})
                && req_addr[DRV_HI:DRV_LO] <= DRV_3QTR));
            default: ok = 1'b1;
          endcase
          rej_nxt = !ok;
          if (ok)
          begin
            bank_nxt = req_bank;
            addr_nxt = req_addr;
            cs_nxt = 1'b0;
            unique case (req_cmd)
              CMD_ACTIVATE:
              begin
                {ras_nxt, cas_nxt, we_nxt} = 3'h3;
                open_nxt[req_bank] = 1'b1;
              end
              CMD_READ, CMD_WRITE:
              begin
                {ras_nxt, cas_nxt} = 2'h2;
                we_nxt = (req_cmd == CMD_READ);
                if (req_addr[AP_BIT])
                  open_nxt[req_bank] = 1'b0;
              end
              CMD_BURST_STOP: {ras_nxt, cas_nxt, we_nxt} = 3'h6;
              CMD_PRECHARGE:
              begin
                {ras_nxt, cas_nxt, we_nxt} = 3'h2;
                if (req_addr[AP_BIT])
                  open_nxt = '0;
                else
                  open_nxt[req_bank] = 1'b0;
              end
              CMD_AUTO_REFRESH: {ras_nxt, cas_nxt, we_nxt} = 3'h1;
              CMD_SELF_REFRESH:
              begin
                {cke_nxt, ras_nxt, cas_nxt, we_nxt} = 4'h1;
                st_nxt = ST_SLEEP;
              end
              CMD_DEEP_SLEEP:
              begin
                {cke_nxt, ras_nxt, cas_nxt, we_nxt} = 4'h6;
                st_nxt = ST_SLEEP;
              end
              CMD_MODE_SET:
              begin
                {ras_nxt, cas_nxt, we_nxt} = 3'h0;
                st_nxt = ST_RECOVER;
                wait_nxt = 8'(MODE_SET_RECOVERY_CYC);
              end
              default: {ras_nxt, cas_nxt, we_nxt} = 3'h7;
            endcase
          end
        end
    endcase
  end

  // Registered pins and state.
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r <= ST_IDLE;
      wait_r <= '0;
      open_r <= '0;
      link.cke <= 1'b1;
      link.cs_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n <= 1'b1;
      link.bank <= '0;
      link.addr <= '0;
      link.dqm <= '0;
      req_reject <= 1'b0;
      req_ready <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      wait_r <= wait_nxt;
      open_r <= open_nxt;
      link.cke <= cke_nxt;
      link.cs_n <= cs_nxt;
      link.ras_n <= ras_nxt;
      link.cas_n <= cas_nxt;
      link.we_n <= we_nxt;
      link.bank <= bank_nxt;
      link.addr <= addr_nxt;
      link.dqm <= req_dqm;
      req_reject <= rej_nxt;
      req_ready <= (st_nxt == ST_IDLE) || (st_nxt == ST_SLEEP);
    end
  end
endmodule

// ===== testbench/lpx_link_properties.sv
// Checker for the command pins that run between the two ends.
// Assumes it is instantiated beside lpx_link_if and sees its signals.
`timescale 1ns/1ps
module lpx_link_properties
  import lpx_pkg::*;
(
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              cke,
  input wire logic              cs_n,
  input wire logic              ras_n,
  input wire logic              cas_n,
  input wire logic              we_n,
  input wire logic [BANK_W-1:0] bank,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [MASK_W-1:0] dqm
);
  logic [2:0]       pins;
  logic             cmd_on;
  logic             ext_set;
  logic [NBANK-1:0] open_r;
  logic [NBANK-1:0] open_nxt;

  // Strobe pattern and the commands the checks key on.
  assign pins    = {ras_n, cas_n, we_n};
  assign cmd_on  = !cs_n && cke;
  assign ext_set = cmd_on && pins == 3'h0 && bank == BANK_SEL_EXT;

  // Tracks which banks the pins have opened and not yet closed.
  always_comb
  begin
    open_nxt = open_r;
    if (cmd_on && pins == 3'h3)
      open_nxt[bank] = 1'b1;
    if (cmd_on && pins[2:1] == 2'h2 && addr[AP_BIT])
      open_nxt[bank] = 1'b0;
    if (cmd_on && pins == 3'h2)
      open_nxt = addr[AP_BIT] ? 4'h0 : open_r & ~(4'h1 << bank);
    if (!rst_n)
      open_nxt = 4'h0;
  end

  // Registers the bank tracking.
  always_ff @(posedge ref_clk)
    open_r <= open_nxt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  property p_ext_zero;
    ext_set |-> addr[11:8] == 4'h0 && addr[4:3] == 2'h0;
  endproperty
  a_ext_zero: assert property (p_ext_zero)
    else $error("extended load with fixed-zero bits set");
  property p_ext_codes;
    ext_set |-> !(addr[2:0] inside {3'h3, 3'h4, 3'h7}) && addr[7:5] <= 3'h4;
  endproperty
  a_ext_codes: assert property (p_ext_codes)
    else $error("extended load with a reserved code");
  property p_recovery;
    cmd_on && pins == 3'h0 |=> cs_n || (cke && pins == 3'h7);
  endproperty
  a_recovery: assert property (p_recovery)
    else $error("command inside mode-set recovery");
  property p_mode_idle;
    cmd_on && pins == 3'h0 |-> open_r == 4'h0;
  endproperty
  a_mode_idle: assert property (p_mode_idle)
    else $error("mode load with a bank open");
  property p_act_closed;
    cmd_on && pins == 3'h3 |-> !open_r[bank];
  endproperty
  a_act_closed: assert property (p_act_closed)
    else $error("activate on an open bank");
  property p_rw_open;
    cmd_on && pins[2:1] == 2'h2 |-> open_r[bank];
  endproperty
  a_rw_open: assert property (p_rw_open)
    else $error("read or write to a closed bank");
  property p_ref_idle;
    !cs_n && pins == 3'h1 |-> open_r == 4'h0;
  endproperty
  a_ref_idle: assert property (p_ref_idle)
    else $error("refresh with a bank open");
  property p_cke_low;
    $fell(cke) |-> !cs_n && (pins == 3'h1 || pins == 3'h6);
  endproperty
  a_cke_low: assert property (p_cke_low)
    else $error("clock enable dropped on a plain command");

  // Main scenarios reached.
  c_ext: cover property (ext_set);
  c_act: cover property (cmd_on && pins == 3'h3);
  c_sref: cover property ($fell(cke) && pins == 3'h1);
  c_deep: cover property ($fell(cke) && pins == 3'h6);
endmodule

// ===== testbench/lpsdram_ext_mode_and_command_decode_tb.sv
// Bench joining controller and device ends with a reference model.
// Assumes lpx_pkg, lpx_link_if, lpx_ctrl and lpx_dev are compiled first.
`timescale 1ns/1ps
module lpsdram_ext_mode_and_command_decode_tb
  import lpx_pkg::*;
;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              req_valid = 1'b0;
  logic [3:0]        req_cmd = 4'h0;
  logic [BANK_W-1:0] req_bank = 2'h0;
  logic [ADDR_W-1:0] req_addr = 12'h000;
  logic [MASK_W-1:0] req_dqm = 4'h0;
  logic              bursts_idle = 1'b1;
  logic [7:0]        temp_code = 8'h10;
  logic              req_ready, req_reject, cov_res, drv_res;
  logic              self_refresh, deep_sleep_state, sref_tick, cmd_valid;
  logic [EXT_W-1:0]  ext_cfg;
  logic [ADDR_W-1:0] base_cfg, cmd_row;
  logic [NBANK-1:0]  bank_open, bank_retained;
  logic [2:0]        drive_code;
  logic [3:0]        cmd_code, wr_mask, rd_mask;
  logic [1:0]        cmd_bank;
  logic [COL_W-1:0]  cmd_col;
  logic              cmd_auto_pre;
  logic [3:0]        op = 4'h0;
  logic [3:0]        ret = 4'h0;
  logic [13:0]       ext = EXT_RESET;
  logic [11:0]       base = BASE_RESET;
  logic [11:0]       rows [NBANK] = '{default: 12'h000};
  int                failures = 0;
  int                n_checks = 0;
  int                cyc = 0;
  int                ticks;

  lpx_link_if link_i();
  lpx_ctrl lpx_ctrl_inst(.ref_clk(ref_clk), .rst_n(rst_n), .link(link_i),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
    .req_addr(req_addr), .req_dqm(req_dqm), .bursts_idle(bursts_idle),
    .req_ready(req_ready), .req_reject(req_reject));
  lpx_dev lpx_dev_inst(.ref_clk(ref_clk), .rst_n(rst_n), .link(link_i),
    .temp_code(temp_code), .ext_cfg(ext_cfg), .base_cfg(base_cfg),
    .bank_open(bank_open), .bank_retained(bank_retained),
    .drive_code(drive_code), .cov_reserved(cov_res),
    .drive_reserved(drv_res), .self_refresh(self_refresh),
    .deep_sleep_state(deep_sleep_state), .sref_tick(sref_tick),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_bank(cmd_bank),
    .cmd_row(cmd_row), .cmd_col(cmd_col), .cmd_auto_pre(cmd_auto_pre),
    .wr_mask(wr_mask), .rd_mask(rd_mask));
  lpx_link_properties lpx_link_properties_inst(.ref_clk(ref_clk),
    .rst_n(rst_n), .cke(link_i.cke), .cs_n(link_i.cs_n),
    .ras_n(link_i.ras_n), .cas_n(link_i.cas_n), .we_n(link_i.we_n),
    .bank(link_i.bank), .addr(link_i.addr), .dqm(link_i.dqm));

  // Free-running 40 MHz clock.
  always #12.5 ref_clk = ~ref_clk;

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Cuts a hung run short.
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      failures++;
      test_done();
    end
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Sends one request, predicts the outcome and checks the device.
  task automatic issue(input lpx_cmd_t c, input logic [1:0] b,
      input logic [11:0] a, input logic [3:0] m);
    logic rej;
    int   n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_bank <= b;
    req_addr <= a;
    req_dqm <= m;
    rej = (c == CMD_ACTIVATE) ? op[b] :
      (c == CMD_READ || c == CMD_WRITE) ? !op[b] :
      (c inside {CMD_AUTO_REFRESH, CMD_SELF_REFRESH, CMD_MODE_SET,
        CMD_DEEP_SLEEP}) && |op;
    if (c == CMD_MODE_SET)
      rej |= !bursts_idle || (b == BANK_SEL_EXT && (|a[11:8] || |a[4:3] ||
        a[2:0] inside {3'h3, 3'h4, 3'h7} || a[7:5] > 3'h4));
    #1;
    while (!req_ready && n < 100)
    begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("req_ready", 1'b1, req_ready);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    #1;
    chk("req_reject", rej, req_reject);
    if (!rej)
      case (c)
        CMD_ACTIVATE:
        begin
          op[b] = 1'b1;
          rows[b] = a;
        end
        CMD_READ: op[b] = op[b] & !a[AP_BIT];
        CMD_WRITE:
        begin
          op[b] = op[b] & !a[AP_BIT];
          ret[b] = 1'b1;
        end
        CMD_PRECHARGE: op = a[AP_BIT] ? 4'h0 : op & ~(4'h1 << b);
        CMD_MODE_SET: if (b == BANK_SEL_EXT) ext = {b, a}; else base = a;
        CMD_SELF_REFRESH: ret &= (ext[2:0] == COV_ALL) ? 4'hf :
          (ext[2:0] == COV_HALF) ? 4'h3 : 4'h1;
        CMD_DEEP_SLEEP: ret = 4'h0;
        default: ;
      endcase
    @(posedge ref_clk);
    #1;
    chk("cmd_valid", !rej && c != CMD_NOP, cmd_valid);
    if (!rej && c != CMD_NOP)
      chk("cmd_code", c, cmd_code);
    if (!rej && c inside {CMD_ACTIVATE, CMD_READ, CMD_WRITE})
      chk("cmd_bank", b, cmd_bank);
    if (!rej && c == CMD_ACTIVATE)
      chk("cmd_row", a, cmd_row);
    if (!rej && (c == CMD_READ || c == CMD_WRITE))
      chk("cmd_row", rows[b], cmd_row);
    if (!rej && c == CMD_AUTO_REFRESH)
      chk("cmd_row", 0, cmd_row);
    if (!rej && (c == CMD_READ || c == CMD_WRITE))
      chk("cmd_col", {a[AP_BIT], a[7:0]}, {cmd_auto_pre, cmd_col});
    if (!rej && c == CMD_WRITE)
      chk("wr_mask", m, wr_mask);
    chk("ext_cfg", ext, ext_cfg);
    chk("base_cfg", base, base_cfg);
    chk("bank_open", op, bank_open);
    chk("bank_retained", ret, bank_retained);
    chk("drive_code", {ext[7:5], 2'h0}, {drive_code, cov_res, drv_res});
    if (!rej && c == CMD_READ)
    begin
      @(posedge ref_clk);
      #1;
      chk("rd_mask", m, rd_mask);
    end
  endtask

  // Main sequence.
  initial
  begin
    void'($urandom(32'h697be0b3));
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 8; i++)
      issue(CMD_MODE_SET, BANK_SEL_EXT,
        {4'h0, 3'($urandom % 5), 2'h0, 3'(i)}, 4'h0);
    for (int i = 0; i < 8; i++)
      issue(CMD_MODE_SET, BANK_SEL_EXT, {4'h0, 3'(i), 5'h01}, 4'h0);
    issue(CMD_MODE_SET, BANK_SEL_EXT, 12'h100, 4'h0);
    issue(CMD_MODE_SET, BANK_SEL_EXT, 12'h008, 4'h0);
    issue(CMD_MODE_SET, BANK_SEL_BASE, 12'h032, 4'h0);
    @(posedge ref_clk);
    bursts_idle <= 1'b0;
    issue(CMD_MODE_SET, BANK_SEL_EXT, 12'h022, 4'h0);
    @(posedge ref_clk);
    bursts_idle <= 1'b1;
    for (int i = 0; i < 4; i++)
      issue(CMD_ACTIVATE, 2'(i), 12'($urandom), 4'h0);
    issue(CMD_ACTIVATE, 2'h1, 12'h0a5, 4'h0);
    for (int i = 0; i < 4; i++)
      issue(CMD_WRITE, 2'(i), 12'($urandom % 256), 4'($urandom));
    issue(CMD_READ, 2'h2, 12'h4c3, 4'h5);
    issue(CMD_READ, 2'h2, 12'h011, 4'h0);
    issue(CMD_READ, 2'h3, 12'($urandom % 256), 4'($urandom));
    issue(CMD_BURST_STOP, 2'h3, 12'h000, 4'h0);
    issue(CMD_MODE_SET, BANK_SEL_EXT, 12'h000, 4'h0);
    issue(CMD_PRECHARGE, 2'h0, 12'h000, 4'h0);
    issue(CMD_PRECHARGE, 2'h3, 12'h400, 4'h0);
    issue(CMD_WRITE, 2'h1, 12'h010, 4'h0);
    issue(CMD_AUTO_REFRESH, 2'h1, 12'($urandom), 4'h0);
    for (int k = 0; k < 2; k++)
    begin
      issue(CMD_MODE_SET, BANK_SEL_EXT,
        {9'h000, k ? COV_QTR : COV_HALF}, 4'h0);
      @(posedge ref_clk);
      temp_code <= k ? 8'($urandom % 45) : TEMP_HOT + 8'($urandom % 32);
      issue(CMD_SELF_REFRESH, 2'h0, 12'h000, 4'h0);
      chk("self_refresh", 1'b1, self_refresh);
      ticks = 0;
      repeat (1536)
      begin
        @(posedge ref_clk);
        #1;
        ticks += int'(sref_tick);
      end
      chk("sref_ticks", 1'b1,
        k ? ticks <= 1 : ticks inside {[2:3]});
      issue(CMD_NOP, 2'h0, 12'h000, 4'h0);
      chk("self_refresh", 1'b0, self_refresh);
    end
    issue(CMD_DEEP_SLEEP, 2'h0, 12'h000, 4'h0);
    chk("deep_sleep", 1'b1, deep_sleep_state);
    issue(CMD_NOP, 2'h0, 12'h000, 4'h0);
    chk("deep_sleep", 1'b0, deep_sleep_state);
    issue(CMD_MODE_SET, BANK_SEL_EXT, 12'h020, 4'h0);
    issue(CMD_MODE_SET, BANK_SEL_BASE, 12'h032, 4'h0);
    test_done();
  end
endmodule
